// [core/ntb_external_side_reset.sv]
`timescale 1ns/1ns
// Notes on behaviour
// - propagate set: external reset resets whole device
// - propagate clear: reset only external side layers
// - external registers reset, keep unlocked and capability
// - action enabled: apply coded not-ready action
// - set opposite reset flag, interrupt if enabled
// - set opposite fundamental reset detected flag
// - port c reset is gpio one alternate
// - selected external: port reset at least 250ns
// - global hot reset: gpio inputs, reset undriven
// - hot reset on ts1, link down, writes
// - port reset output is active low
module ntb_external_side_reset
    import ntb_reset_pkg::*;
#(
    parameter int unsigned FULL_CYC = ntb_reset_pkg::FULL_RST_CYC
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // pins and link events
    input  wire logic        bridge_fundamental_reset_in_n,
    input  wire logic        upstream_hot_reset_ts1,
    input  wire logic        upstream_link_down,
    input  wire logic        gpio1_alt_enable,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    // gpio pin 1 (port c reset out)
    output logic             gpio1_out,
    output logic             gpio1_oe,
    // resets to the rest of the device
    output logic             device_fundamental_reset,
    output logic             ext_layers_reset,
    output logic             ext_regs_reset,
    output logic             internal_hot_reset,
    // readiness and interrupt
    output logic             internal_not_ready,
    output logic             external_not_ready,
    output logic             irq,
    output logic             msi_req
);
    initial begin
        if (FULL_CYC < 1) $error("ntb_external_side_reset: FULL_CYC must be at least 1");
    end

    localparam int unsigned FW = $clog2(FULL_CYC + 1);

    typedef struct packed {
        logic [8:0]          control;      // mode, propagate, action, select
        logic [EV_WIDTH-1:0] status;       // sticky events
        logic [EV_WIDTH-1:0] mask;         // interrupt enables
        logic                fund_flag;    // opposite fundamental reset detected
        logic                int_nr;       // internal side not ready
        logic                ext_nr;       // external side not ready
        logic                in_prev;      // last sampled reset pin (active high)
        logic [FW-1:0]       full_cnt;     // device reset pulse counter
        logic                dev_rst;      // device fundamental reset out
        logic                ext_rst;      // external layer reset out
        logic                hot;          // internal hot reset pulse
        logic                gpio_input;   // gpio reverted to input
        logic [31:0]         rdata;        // read data
        logic                irq;          // level interrupt
        logic                msi;          // msi pulse
    } top_state_t;

    top_state_t st_reg;
    top_state_t st_next;

    logic ext_in;        // reset pin asserted
    logic ext_edge;      // reset pin newly asserted
    logic propagate;     // either side asks to propagate
    logic ext_only;      // external only reset start
    logic hot_start;     // internal hot reset cause
    logic port_trig;     // start of port reset pulse
    logic port_active;   // port reset held
    logic wr_ctl;
    logic wr_cmd;
    logic [EV_WIDTH-1:0] ev_set;
    logic [EV_WIDTH-1:0] pending;

    // decode of pin and commands
    always_comb begin
        ext_in    = !bridge_fundamental_reset_in_n;
        ext_edge  = ext_in && !st_reg.in_prev && st_reg.control[CTL_NT_MODE];
        propagate = st_reg.control[CTL_PROP_INT] || st_reg.control[CTL_PROP_EXT];
        ext_only  = ext_edge && !propagate;
        wr_ctl    = reg_write && (reg_addr == OFS_CONTROL);
        wr_cmd    = reg_write && (reg_addr == OFS_COMMAND);
        hot_start = upstream_hot_reset_ts1 || upstream_link_down
                    || (wr_cmd && reg_wdata[CMD_BRIDGE_RST])
                    || (wr_cmd && reg_wdata[CMD_SEC_BUS_RST]);
        port_trig = ext_edge && (st_reg.control[CTL_OUT_SEL_LO +: 2] == OUT_SEL_EXTERNAL);
        ev_set               = '0;
        ev_set[EV_OPP_RESET] = ext_only;
        ev_set[EV_OPP_FUND]  = ext_only;
        ev_set[EV_HOT_RESET] = hot_start;
        pending              = st_reg.status & st_reg.mask;
    end

    // port reset pulse: minimum width, extended while pin held
    pulse_stretch #(
        .MIN_CYC (PORT_RST_MIN_CYC)
    ) u_port_stretch (
        .clk     (clk),
        .rst_n   (rst_n),
        .trigger (port_trig),
        .hold    (ext_in),
        .active  (port_active)
    );

    // main next state
    always_comb begin
        st_next         = st_reg;
        st_next.in_prev = ext_in && st_reg.control[CTL_NT_MODE];
        st_next.msi     = 1'b0;
        st_next.hot     = hot_start;
        st_next.rdata   = 32'h0000_0000;
        // device-wide reset pulse on propagated external reset
        if (ext_edge && propagate) begin
            st_next.dev_rst  = 1'b1;
            st_next.full_cnt = FW'(FULL_CYC - 1);
        end else if (st_reg.full_cnt != '0) begin
            st_next.full_cnt = st_reg.full_cnt - FW'(1);
        end else begin
            st_next.dev_rst = 1'b0;
        end
        // external layers held while the pin stays asserted
        st_next.ext_rst = ext_in && st_reg.control[CTL_NT_MODE] && !propagate;
        // register writes
        if (wr_ctl) begin
            st_next.control = reg_wdata[8:0];
        end
        if (reg_write && (reg_addr == OFS_INT_MASK)) begin
            st_next.mask = reg_wdata[EV_WIDTH-1:0];
        end
        // write one to clear not-ready or fund flag in bridge status
        if (reg_write && (reg_addr == OFS_BRIDGE_STATUS)) begin
            if (reg_wdata[0]) st_next.fund_flag = 1'b0;
            if (reg_wdata[1]) st_next.int_nr    = 1'b0;
            if (reg_wdata[2]) st_next.ext_nr    = 1'b0;
        end
        // reads
        if (reg_read) begin
            case (reg_addr)
                OFS_CONTROL:       st_next.rdata = {23'h00_0000, st_reg.control};
                OFS_INT_STATUS: begin
                    st_next.rdata  = {29'h0000_0000, st_reg.status};
                    st_next.status = '0;                                       // clear on read
                end
                OFS_INT_MASK:      st_next.rdata = {29'h0000_0000, st_reg.mask};
                OFS_BRIDGE_STATUS: st_next.rdata = {29'h0000_0000, st_reg.ext_nr,
                                                    st_reg.int_nr, st_reg.fund_flag};
                default:           st_next.rdata = 32'h0000_0000;
            endcase
        end
        // events win over clears
        st_next.status = st_next.status | ev_set;
        if (ext_only) begin
            st_next.fund_flag = 1'b1;
            if (st_reg.control[CTL_ACT_EN]) begin
                case (st_reg.control[CTL_ACT_LO +: 2])
                    ACT_INT_NOT_READY:  st_next.int_nr = 1'b1;
                    ACT_EXT_NOT_READY:  st_next.ext_nr = 1'b1;
                    ACT_BOTH_NOT_READY: begin
                        st_next.int_nr = 1'b1;
                        st_next.ext_nr = 1'b1;
                    end
                    default: ;
                endcase
            end
            if (st_reg.mask[EV_OPP_RESET] && st_reg.control[CTL_MSI_SEL]) begin
                st_next.msi = 1'b1;
            end
        end
        st_next.irq = |(st_next.status & st_reg.mask) && !st_reg.control[CTL_MSI_SEL];
        // global hot reset returns gpio to input mode
        if (hot_start) begin
            st_next.gpio_input = 1'b1;
        end else if (wr_ctl || !gpio1_alt_enable) begin
            st_next.gpio_input = !gpio1_alt_enable;
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg            <= '0;
            st_reg.control    <= CONTROL_RESET;
            st_reg.mask       <= MASK_RESET;
            st_reg.gpio_input <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // output register for gpio pin
    logic gpio_out_reg;
    logic gpio_oe_reg;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gpio_out_reg <= 1'b1;
            gpio_oe_reg  <= 1'b0;
        end else begin
            gpio_out_reg <= !port_active;
            gpio_oe_reg  <= gpio1_alt_enable && !st_next.gpio_input;
        end
    end

    // outputs
    assign reg_rdata                = st_reg.rdata;
    assign gpio1_out                = gpio_out_reg;
    assign gpio1_oe                 = gpio_oe_reg;
    assign device_fundamental_reset = st_reg.dev_rst;
    assign ext_layers_reset         = st_reg.ext_rst;
    assign ext_regs_reset           = st_reg.ext_rst;
    assign internal_hot_reset       = st_reg.hot;
    assign internal_not_ready       = st_reg.int_nr;
    assign external_not_ready       = st_reg.ext_nr;
    assign irq                      = st_reg.irq;
    assign msi_req                  = st_reg.msi;
endmodule : ntb_external_side_reset

// [core/ntb_reset_pkg.sv]
package ntb_reset_pkg;
    // timing
    localparam int unsigned CLK_PERIOD_NS      = 8;       // core clock period
    localparam int unsigned PORT_RST_MIN_NS    = 250;     // least reset pulse width
    localparam int unsigned PORT_RST_MIN_CYC   =
        (PORT_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned FULL_RST_CYC       = 16;      // length of device reset pulse
    // register offsets (plain port, byte offset)
    localparam logic [7:0] OFS_CONTROL         = 8'h00;   // mode, propagate, action, select
    localparam logic [7:0] OFS_INT_STATUS      = 8'h04;   // sticky events, clear on read
    localparam logic [7:0] OFS_INT_MASK        = 8'h08;   // interrupt enables
    localparam logic [7:0] OFS_BRIDGE_STATUS   = 8'h0C;   // detection flags and readiness
    localparam logic [7:0] OFS_COMMAND         = 8'h10;   // write-one reset requests
    // control field positions
    localparam int unsigned CTL_NT_MODE        = 0;
    localparam int unsigned CTL_PROP_INT       = 1;
    localparam int unsigned CTL_PROP_EXT       = 2;
    localparam int unsigned CTL_ACT_EN         = 3;
    localparam int unsigned CTL_ACT_LO         = 4;       // reset_action, 2 bits
    localparam int unsigned CTL_OUT_SEL_LO     = 6;       // bridge_reset_output_select, 2 bits
    localparam int unsigned CTL_MSI_SEL        = 8;       // select msi instead of level line
    // interrupt / status event positions
    localparam int unsigned EV_OPP_RESET       = 0;       // opposite side reset detected
    localparam int unsigned EV_OPP_FUND        = 1;       // opposite side fundamental reset
    localparam int unsigned EV_HOT_RESET       = 2;       // internal hot reset started
    localparam int unsigned EV_WIDTH           = 3;
    // command bit positions
    localparam int unsigned CMD_BRIDGE_RST     = 0;       // port c bridge reset bit
    localparam int unsigned CMD_SEC_BUS_RST    = 1;       // upstream secondary bus reset bit
    // reset values
    localparam logic [8:0] CONTROL_RESET       = 9'h000;
    localparam logic [2:0] MASK_RESET          = 3'h0;
    // reset action codes
    localparam logic [1:0] ACT_NONE            = 2'h0;
    localparam logic [1:0] ACT_INT_NOT_READY   = 2'h1;
    localparam logic [1:0] ACT_EXT_NOT_READY   = 2'h2;
    localparam logic [1:0] ACT_BOTH_NOT_READY  = 2'h3;
    // output select codes
    localparam logic [1:0] OUT_SEL_EXTERNAL    = 2'h1;
endpackage : ntb_reset_pkg

// [core/pulse_stretch.sv]
`timescale 1ns/1ns
// holds its output for at least MIN_CYC cycles after a trigger and while hold stays high
module pulse_stretch #(
    parameter int unsigned MIN_CYC = 32
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // control
    input  wire logic trigger,
    input  wire logic hold,
    output logic      active
);
    localparam int unsigned CW = $clog2(MIN_CYC + 1);
    initial begin
        if (MIN_CYC < 1) $error("pulse_stretch: MIN_CYC must be at least 1");
    end

    typedef struct packed {
        logic [CW-1:0] count;   // remaining cycles
        logic          on;      // output active
    } ps_state_t;

    ps_state_t st_reg;
    ps_state_t st_next;

    // next state: reload on trigger, count down, drop when done and hold gone
    always_comb begin
        st_next = st_reg;
        if (trigger) begin
            st_next.count = CW'(MIN_CYC - 1);
            st_next.on    = 1'b1;
        end else if (st_reg.count != '0) begin
            st_next.count = st_reg.count - CW'(1);
        end else if (!hold) begin
            st_next.on = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign active = st_reg.on;
endmodule : pulse_stretch

// [tb/ext_root_model.sv]
`timescale 1ns/1ns
// external root: holds the bridge reset pin low for a requested count
module ext_root_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // request from the bench
    input  wire logic       go,
    input  wire logic [7:0] len,
    // bridge reset pin
    output logic            pin_n
);
    logic [7:0] cnt;  // cycles of low level left
    // pin is low while cycles remain
    assign pin_n = (cnt == 8'h00);
    // count down the low time
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt <= 8'h00;
        end else if (go) begin
            cnt <= len;
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
        end
    end
endmodule : ext_root_model

// [tb/ntb_external_side_reset_tb_top.sv]
`timescale 1ns/1ns
module ntb_external_side_reset_tb_top;
    import ntb_reset_pkg::*;
    logic        clk, rst_n, go, ts1, ldn, alt, reg_write, reg_read;
    logic [7:0]  len, reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic        pin_n, g_out, g_oe, dfr, ext_l, ext_r, ihr, int_nr, ext_nr, irq, msi;
    int          fail_count, comparisons, msi_n, dfr_n, hot_n, a;
    ext_root_model i_root (.clk(clk), .rst_n(rst_n), .go(go), .len(len), .pin_n(pin_n));
    ntb_external_side_reset #(.FULL_CYC(4)) i_dut (.clk(clk), .rst_n(rst_n),
        .bridge_fundamental_reset_in_n(pin_n), .upstream_hot_reset_ts1(ts1),
        .upstream_link_down(ldn), .gpio1_alt_enable(alt), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .gpio1_out(g_out), .gpio1_oe(g_oe),
        .device_fundamental_reset(dfr), .ext_layers_reset(ext_l), .ext_regs_reset(ext_r),
        .internal_hot_reset(ihr), .internal_not_ready(int_nr), .external_not_ready(ext_nr),
        .irq(irq), .msi_req(msi));
    // 125 mhz core clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // event counters for pulse outputs
    always @(posedge clk) begin
        msi_n <= msi_n + (msi === 1'b1);
        dfr_n <= dfr_n + (dfr === 1'b1);
        hot_n <= hot_n + (ihr === 1'b1);
    end
    task automatic report_and_stop;
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= ad;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr
    // read, then compare the masked data in the cycle after
    task automatic rd(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= ad;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 chk(reg_rdata & m, e);
    endtask : rd
    // external root pulls the pin low for n cycles; wait four cycles after the request, not for the release
    task automatic pulse(input logic [7:0] n);
        @(posedge clk);
        go  <= 1'b1;
        len <= n;
        @(posedge clk);
        go <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask : pulse
    initial begin
        {rst_n, go, ts1, ldn, reg_write, reg_read, len, reg_addr, reg_wdata} = '0;
        {msi_n, dfr_n, hot_n, fail_count, comparisons} = '0;
        alt = 1'b1;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        #1 chk(g_out, 1);
        chk(g_oe, 0);
        // external-only reset with port reset selected
        wr(8'h08, 32'h1);
        wr(8'h00, 32'h41);
        pulse(8'd40);
        chk({g_oe, g_out, ext_l, ext_r, dfr, irq}, 6'b101101);
        rd(8'h0C, 32'h1, 32'h1);
        rd(8'h04, 32'h1, 32'h1);
        @(posedge clk);
        #1 chk(irq, 0);
        for (a = 0; a < 200 && g_out !== 1'b1; a++) @(posedge clk);
        chk(a > 32 && a < 200, 1);
        // reset action codes 1 to 3 (not ACT_NONE), port reset not selected
        for (a = 1; a < 4; a++) begin
            wr(8'h0C, 32'h6);
            wr(8'h00, 32'h9 | (a << 4));
            pulse(8'd2);
            chk({ext_nr, int_nr}, a);
            chk(g_out, 1);
            rd(8'h0C, 32'h6, a << 1);
        end
        // msi selected instead of the level line
        rd(8'h04, 32'h0, 32'h0);
        wr(8'h00, 32'h141);
        pulse(8'd2);
        chk({msi_n[7:0], irq}, 9'h002);
        // propagate bit: full device reset instead
        wr(8'h00, 32'h5);
        pulse(8'd2);
        // the last of the four high cycles is counted one edge after the pulse task ends
        repeat (2) @(posedge clk);
        #1 chk(dfr_n, 4);
        // every hot reset cause
        wr(8'h00, 32'h41);
        @(posedge clk);
        #1 chk(g_oe, 1);
        wr(8'h10, 32'h1);
        wr(8'h10, 32'h2);
        ts1 <= 1'b1;
        @(posedge clk);
        ts1 <= 1'b0;
        ldn <= 1'b1;
        @(posedge clk);
        ldn <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk({hot_n[7:0], g_oe}, 9'h008);
        rd(8'h20, 32'hFFFF_FFFF, 32'h0);
        report_and_stop();
    end
endmodule : ntb_external_side_reset_tb_top

// [tb/ntb_reset_checker_asserts.sv]
`timescale 1ns/1ns
// port-level checks on the external side reset block
module ntb_reset_checker
    import ntb_reset_pkg::*;
#(
    parameter int unsigned FULL_CYC = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic bridge_fundamental_reset_in_n,
    input wire logic upstream_hot_reset_ts1,
    input wire logic upstream_link_down,
    input wire logic gpio1_out,
    input wire logic gpio1_oe,
    input wire logic device_fundamental_reset,
    input wire logic ext_layers_reset,
    input wire logic ext_regs_reset,
    input wire logic internal_hot_reset
);
    logic [15:0] hi_cnt;  // cycles the device reset has been high
    logic [15:0] lo_cnt;  // cycles the port reset pin has been low
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // run-length counters for the pulse width checks
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hi_cnt <= 16'h0000;
            lo_cnt <= 16'h0000;
        end else begin
            hi_cnt <= device_fundamental_reset ? hi_cnt + 16'h0001 : 16'h0000;
            lo_cnt <= gpio1_out ? 16'h0000 : lo_cnt + 16'h0001;
        end
    end
    // link hot reset causes (ts1 or link down) seen at the edge
    sequence hot_cause;
        upstream_hot_reset_ts1 || upstream_link_down;
    endsequence
    // port reset held past its minimum with the pin already released
    sequence port_done;
        !gpio1_out && lo_cnt >= PORT_RST_MIN_CYC && bridge_fundamental_reset_in_n;
    endsequence
    full_len_a:    assert property ($fell(device_fundamental_reset) |-> hi_cnt == FULL_CYC)
        else $error("device reset pulse has wrong length");
    no_both_a:     assert property (!(device_fundamental_reset && ext_layers_reset))
        else $error("full and external-only reset together");
    layers_pin_a:  assert property (ext_layers_reset |-> !$past(bridge_fundamental_reset_in_n))
        else $error("external layers reset without the pin low");
    regs_layers_a: assert property (ext_layers_reset |-> ext_regs_reset)
        else $error("external registers not reset with the layers");
    port_min_a:    assert property ($rose(gpio1_out) |-> lo_cnt >= PORT_RST_MIN_CYC)
        else $error("port reset shorter than its minimum");
    port_cause_a:  assert property ($fell(gpio1_out) |-> !$past(bridge_fundamental_reset_in_n, 2))
        else $error("port reset driven low without the pin low");
    hot_start_a:   assert property (hot_cause |=> internal_hot_reset)
        else $error("hot reset cause not followed by hot reset");
    hot_input_a:   assert property (internal_hot_reset |-> !gpio1_oe)
        else $error("gpio still driven during hot reset");
    port_free_a:   assert property (port_done |-> ##[0:3] gpio1_out)
        else $error("port reset not released");
endmodule : ntb_reset_checker

bind ntb_external_side_reset ntb_reset_checker #(.FULL_CYC(FULL_CYC)) i_chk (
    .clk, .rst_n, .bridge_fundamental_reset_in_n, .upstream_hot_reset_ts1, .upstream_link_down,
    .gpio1_out, .gpio1_oe, .device_fundamental_reset, .ext_layers_reset, .ext_regs_reset,
    .internal_hot_reset
);
